// *** irlg_defines.svh ***
`ifndef IRLG_DEFINES_SVH
`define IRLG_DEFINES_SVH
// ----------------------------------------------------------
// Register map
// ----------------------------------------------------------
`define IRLG_ADDR_W 12
`define IRLG_REQ_ADDR 12'hFC0
`define IRLG_WORD_LSB 2
`define IRLG_RESET_VAL 8'h00
`define IRLG_NUM_SRC 8
// ----------------------------------------------------------
// Bit positions of the pending latch
// ----------------------------------------------------------
`define IRLG_BIT_PWM 7
`define IRLG_BIT_FAULT 6
`define IRLG_BIT_ADC 5
`define IRLG_BIT_CMP 4
`define IRLG_BIT_TMR0 3
`define IRLG_BIT_URX 2
`define IRLG_BIT_UTX 1
`define IRLG_BIT_SPI 0
// ----------------------------------------------------------
// Bus answers and fault source slots
// ----------------------------------------------------------
`define IRLG_RESP_OKAY 2'h0
`define IRLG_RESP_SLVERR 2'h2
`define IRLG_FLT_A 0
`define IRLG_FLT_B 1
`define IRLG_FLT_CMP 2
`define IRLG_NUM_FLT 3
`endif

// *** irlg_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------
// Shared types
// ----------------------------------------------------------
package irlg_pkg;
  // Write channel state, Gray along idle-addr-resp
  typedef enum logic [1:0] {
    IRLG_WR_IDLE = 2'h0,
    IRLG_WR_ADDR = 2'h1,
    IRLG_WR_RESP = 2'h3,
    IRLG_WR_DATA = 2'h2
  } irlg_wr_state_e;
  // Read channel state
  typedef enum logic {
    IRLG_RD_IDLE = 1'h0,
    IRLG_RD_RESP = 1'h1
  } irlg_rd_state_e;
  // One pending bit per source
  typedef logic [7:0] irlg_pend_t;
endpackage
`default_nettype wire

// *** irlg_fault_if.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "irlg_defines.svh"
// ----------------------------------------------------------
// Fault sources and their enables, plus the merged request
// ----------------------------------------------------------
interface irlg_fault_if;
  logic [`IRLG_NUM_FLT-1:0] fault_src; // Pin a, pin b, comparator
  logic [`IRLG_NUM_FLT-1:0] fault_en; // Enables from PWM side
  logic fault_req; // One-cycle merged request
  // Fault gating end
  modport gate (
    input fault_src,
    input fault_en,
    output fault_req
  );
  // Latch end
  modport latch (
    output fault_src,
    output fault_en,
    input fault_req
  );
endinterface
`default_nettype wire

// *** irlg_fault_gate.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "irlg_defines.svh"
// ----------------------------------------------------------
// Fault request merge: edge of each enabled source
// ----------------------------------------------------------
module irlg_fault_gate
  import irlg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  irlg_fault_if.gate flt
);
  // Previous source levels for edge detection
  logic [`IRLG_NUM_FLT-1:0] prev_q;
  // New assertions of each source
  logic [`IRLG_NUM_FLT-1:0] rise;

  // Remember source levels
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prev_q <= '0;
    end else if (clk_en_in) begin
      prev_q <= flt.fault_src;
    end
  end

  // Each source gated by its own enable
  assign rise = flt.fault_src & ~prev_q & flt.fault_en;
  // Forced low while the clock enable is low
  assign flt.fault_req = clk_en_in & (|rise);

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_flt_masked;
    @(posedge sys_clk_in) disable iff (rst_in)
      (flt.fault_en == '0) |-> !flt.fault_req;
  endproperty
  a_flt_masked: assert property (p_flt_masked)
    else $error("fault request with all sources masked");

  property p_flt_edge;
    @(posedge sys_clk_in) disable iff (rst_in)
      clk_en_in ##1 (clk_en_in && |(flt.fault_src
        & ~$past(flt.fault_src) & flt.fault_en))
      |-> flt.fault_req;
  endproperty
  a_flt_edge: assert property (p_flt_edge)
    else $error("enabled fault edge not forwarded");
endmodule
`default_nettype wire

// *** irlg_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "irlg_defines.svh"
// Function
// - Source request sets its pending bit
// - Global enable forwards pending bits set in src_enable_in as vectored request
// - Disabled: no vector, software polls latch
// - Eight-bit latch at FC0, reset zero
// - Bit 7 holds PWM timer request
// - Bit 6 holds merged fault request
// - Each fault source has own enable
// - Bit 5 holds converter request
// - Bit 4 holds comparator request
// - Bit 3 holds timer zero request
// - Bit 2 holds UART receiver request
// - Bit 1 holds UART transmitter request
// - Bit 0 holds SPI request
// - Vector acknowledge clears that bit
// - Software write of zero clears bit
// - Software write of one raises bit
// - One global enable selects vector or poll
module irlg_latch
  import irlg_pkg::*;
#(
  parameter int ADDR_W = `IRLG_ADDR_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Source requests
  input wire logic pwm_timer_req_in,
  input wire logic converter_req_in,
  input wire logic comparator_req_in,
  input wire logic timer_zero_req_in,
  input wire logic uart_rx_req_in,
  input wire logic uart_tx_req_in,
  input wire logic spi_req_in,
  // Fault sources and their PWM-side enables
  input wire logic fault_pin_a_in,
  input wire logic fault_pin_b_in,
  input wire logic fault_cmp_in,
  input wire logic [2:0] fault_src_en_in,
  // Core side
  input wire logic global_interrupt_enable_in,
  input wire logic [7:0] src_enable_in,
  input wire logic vec_ack_in,
  input wire logic [2:0] vec_ack_index_in,
  output logic vectored_req_out,
  output logic [7:0] pending_request_group_a_out,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  irlg_pend_t pending_q; // The request latch
  irlg_pend_t pending_d; // Its next value
  irlg_pend_t hw_set; // Hardware requests this cycle
  irlg_pend_t ack_mask; // Bit cleared by acknowledge
  irlg_pend_t base; // Value before hardware sets
  irlg_wr_state_e wr_q; // Write channel state
  irlg_wr_state_e wr_d; // Its next value
  irlg_rd_state_e rd_q; // Read channel state
  logic [ADDR_W-1:0] awaddr_q; // Held write address
  logic [7:0] wdata_q; // Held write data, low byte
  logic wstrb_q; // Held low-lane strobe
  logic [1:0] bresp_q; // Write answer
  logic [31:0] rdata_q; // Read data
  logic [1:0] rresp_q; // Read answer
  logic aw_hs; // Write address taken
  logic w_hs; // Write data taken
  logic ar_hs; // Read address taken
  logic wr_do; // Write is carried out now
  logic [ADDR_W-1:0] eff_addr; // Address of that write
  logic [7:0] eff_data; // Data of that write
  logic eff_strb; // Low-lane strobe of that write
  logic wr_hit; // Write lands on the latch
  logic sw_wr; // Latch written by software
  irlg_fault_if flt(); // Link to the fault gate
  localparam logic [ADDR_W-1:0] REQ_ADDR = ADDR_W'(`IRLG_REQ_ADDR); // Latch
  // ----------------------------------------------------------
  // Fault request merge
  // ----------------------------------------------------------
  // Sources and enables enter from the PWM side
  assign flt.fault_src[`IRLG_FLT_A] = fault_pin_a_in;
  assign flt.fault_src[`IRLG_FLT_B] = fault_pin_b_in;
  assign flt.fault_src[`IRLG_FLT_CMP] = fault_cmp_in;
  assign flt.fault_en = fault_src_en_in;

  // Edge of an enabled fault source
  irlg_fault_gate u_fault (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .flt(flt.gate)
  );
  // ----------------------------------------------------------
  // Hardware requests onto latch bits
  // ----------------------------------------------------------
  always_comb begin
    hw_set = '0;
    hw_set[`IRLG_BIT_PWM] = pwm_timer_req_in;
    hw_set[`IRLG_BIT_FAULT] = flt.fault_req;
    hw_set[`IRLG_BIT_ADC] = converter_req_in;
    hw_set[`IRLG_BIT_CMP] = comparator_req_in;
    hw_set[`IRLG_BIT_TMR0] = timer_zero_req_in;
    hw_set[`IRLG_BIT_URX] = uart_rx_req_in;
    hw_set[`IRLG_BIT_UTX] = uart_tx_req_in;
    hw_set[`IRLG_BIT_SPI] = spi_req_in;
  end
  // ----------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------
  // Readies drop while frozen so nothing is taken
  assign s_axi_awready = clk_en_in
    & ((wr_q == IRLG_WR_IDLE) | (wr_q == IRLG_WR_DATA));
  assign s_axi_wready = clk_en_in
    & ((wr_q == IRLG_WR_IDLE) | (wr_q == IRLG_WR_ADDR));
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;

  // Use the live channel if taken now, else the held one
  assign eff_addr = aw_hs ? s_axi_awaddr : awaddr_q;
  assign eff_data = w_hs ? s_axi_wdata[7:0] : wdata_q;
  assign eff_strb = w_hs ? s_axi_wstrb[0] : wstrb_q;
  assign wr_hit = (eff_addr[ADDR_W-1:`IRLG_WORD_LSB]
    == REQ_ADDR[ADDR_W-1:`IRLG_WORD_LSB]);
  // Next write state
  always_comb begin
    wr_d = wr_q;
    unique case (wr_q)
      IRLG_WR_IDLE: begin
        if (aw_hs && w_hs) begin
          wr_d = IRLG_WR_RESP;
        end else if (aw_hs) begin
          wr_d = IRLG_WR_ADDR;
        end else if (w_hs) begin
          wr_d = IRLG_WR_DATA;
        end
      end
      IRLG_WR_ADDR: begin
        if (w_hs) begin
          wr_d = IRLG_WR_RESP;
        end
      end
      IRLG_WR_DATA: begin
        if (aw_hs) begin
          wr_d = IRLG_WR_RESP;
        end
      end
      IRLG_WR_RESP: begin
        if (s_axi_bready && clk_en_in) begin
          wr_d = IRLG_WR_IDLE;
        end
      end
    endcase
  end

  // Write happens when both halves are in hand
  assign wr_do = (wr_d == IRLG_WR_RESP) & (wr_q != IRLG_WR_RESP);
  assign sw_wr = wr_do & wr_hit & eff_strb;
  // Write state register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_q <= IRLG_WR_IDLE;
    end else if (clk_en_in) begin
      wr_q <= wr_d;
    end
  end

  // Hold address and data taken ahead of the other half
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 1'b0;
    end else if (clk_en_in) begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
    end
  end

  // Write answer: error for any other address
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bresp_q <= `IRLG_RESP_OKAY;
    end else if (clk_en_in && wr_do) begin
      bresp_q <= wr_hit ? `IRLG_RESP_OKAY : `IRLG_RESP_SLVERR;
    end
  end
  assign s_axi_bvalid = (wr_q == IRLG_WR_RESP);
  assign s_axi_bresp = bresp_q;
  // ----------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------
  assign s_axi_arready = clk_en_in & (rd_q == IRLG_RD_IDLE);
  assign ar_hs = s_axi_arvalid & s_axi_arready;

  // Read state and data; latch returns its live bits
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_q <= IRLG_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= `IRLG_RESP_OKAY;
    end else if (clk_en_in) begin
      unique case (rd_q)
        IRLG_RD_IDLE: begin
          if (ar_hs) begin
            rd_q <= IRLG_RD_RESP;
            if (s_axi_araddr[ADDR_W-1:`IRLG_WORD_LSB]
                == REQ_ADDR[ADDR_W-1:`IRLG_WORD_LSB]) begin
              rdata_q <= {24'h000000, pending_q};
              rresp_q <= `IRLG_RESP_OKAY;
            end else begin
              rdata_q <= '0;
              rresp_q <= `IRLG_RESP_SLVERR;
            end
          end
        end
        IRLG_RD_RESP: begin
          if (s_axi_rready) begin
            rd_q <= IRLG_RD_IDLE;
          end
        end
      endcase
    end
  end
  assign s_axi_rvalid = (rd_q == IRLG_RD_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // ----------------------------------------------------------
  // Request latch
  // ----------------------------------------------------------
  // Bit of the source the core is vectoring to
  always_comb begin
    ack_mask = '0;
    if (vec_ack_in) begin
      ack_mask[vec_ack_index_in] = 1'b1;
    end
  end

  // Software value replaces, acknowledge clears, set wins
  always_comb begin
    base = sw_wr ? eff_data : pending_q;
    base = base & ~ack_mask;
    pending_d = base | hw_set;
  end

  // Latch register, cleared at reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pending_q <= `IRLG_RESET_VAL;
    end else if (clk_en_in) begin
      pending_q <= pending_d;
    end
  end
  assign pending_request_group_a_out = pending_q;
  // ----------------------------------------------------------
  // Vectored request to the core
  // ----------------------------------------------------------
  // Only with the global enable and an enabled pending bit
  assign vectored_req_out = global_interrupt_enable_in
    & (|(pending_q & src_enable_in));
  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence s_rd_latch;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr
      [ADDR_W-1:`IRLG_WORD_LSB] == REQ_ADDR[ADDR_W-1:`IRLG_WORD_LSB]);
  endsequence
  sequence s_rd_answer;
    s_axi_rvalid && (s_axi_rdata[7:0] == $past(pending_q))
      && (s_axi_rdata[31:8] == 24'h000000);
  endsequence
  property p_rd_live;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_rd_latch |=> s_rd_answer;
  endproperty
  a_rd_live: assert property (p_rd_live)
    else $error("latch read does not return pending bits");
  property p_reset_zero;
    @(posedge sys_clk_in)
      rst_in |=> (pending_q == `IRLG_RESET_VAL);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("latch not cleared by reset");
  property p_hw_set;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && hw_set != '0)
      |=> ((pending_q & $past(hw_set)) == $past(hw_set));
  endproperty
  a_hw_set: assert property (p_hw_set)
    else $error("source request did not set its bit");
  property p_set_wins;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && hw_set != '0 && (sw_wr || vec_ack_in))
      |=> ((pending_q & $past(hw_set)) == $past(hw_set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous request");
  property p_ack_clear;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && vec_ack_in && !hw_set[vec_ack_index_in])
      |=> !pending_q[$past(vec_ack_index_in)];
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledged bit still pending");
  property p_sw_write;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && sw_wr && !vec_ack_in) |=> (pending_q
        == ($past(eff_data) | $past(hw_set)));
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software write not applied to latch");
  property p_vector_on;
    @(posedge sys_clk_in) disable iff (rst_in)
      (global_interrupt_enable_in && |(pending_q & src_enable_in))
      |-> vectored_req_out;
  endproperty
  a_vector_on: assert property (p_vector_on)
    else $error("enabled pending request not vectored");
  property p_vector_off;
    @(posedge sys_clk_in) disable iff (rst_in)
      !global_interrupt_enable_in |-> !vectored_req_out;
  endproperty
  a_vector_off: assert property (p_vector_off)
    else $error("vectored request while globally disabled");
  property p_write_answer;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && wr_do) |=> s_axi_bvalid
        && (s_axi_bresp == ($past(wr_hit) ? `IRLG_RESP_OKAY
        : `IRLG_RESP_SLVERR));
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write answer missing or wrong");
  property p_freeze;
    @(posedge sys_clk_in) disable iff (rst_in)
      !clk_en_in |=> $stable(pending_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("latch changed while clock enable low");
endmodule
`default_nettype wire

// *** irlg_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------
// Core side: takes vectored requests and acknowledges them
// ----------------------------------------------------------
module irlg_core_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic vectored_req_in,
  input wire logic [7:0] pending_in,
  input wire logic [7:0] src_enable_in,
  input wire logic ack_en_in,
  input wire logic [3:0] ack_delay_in,
  output logic vec_ack_out,
  output logic [2:0] vec_ack_index_out
);
  logic [3:0] wait_q; // Cycles spent before answering
  // Highest enabled pending source wins the vector
  function automatic logic [2:0] top_src(input logic [7:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction
  // Acknowledge only a raised vectored request, after a set delay
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wait_q <= 4'h0;
      vec_ack_out <= 1'b0;
      vec_ack_index_out <= 3'h0;
    end else if (vec_ack_out) begin
      // One-cycle pulse; index is garbage afterwards
      vec_ack_out <= 1'b0;
      vec_ack_index_out <= ~vec_ack_index_out;
      wait_q <= 4'h0;
    end else if (vectored_req_in && ack_en_in) begin
      if (wait_q >= ack_delay_in) begin
        vec_ack_out <= 1'b1;
        vec_ack_index_out <= top_src(pending_in & src_enable_in);
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      // No request: polled mode, index not meaningful
      wait_q <= 4'h0;
      vec_ack_index_out <= ~vec_ack_index_out;
    end
  end
endmodule
`default_nettype wire

// *** tb_irlg_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "irlg_defines.svh"
module tb_irlg_latch
  import irlg_pkg::*;
;
  // ----------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------
  logic clk, rst, clk_en, gie, ack_en, vec_ack, vreq;
  logic [7:0] src_req, src_en; // Source requests and enables
  logic [2:0] flt, flt_en, vec_idx; // Fault pins and enables
  logic [3:0] ack_dly; // Core answer delay
  irlg_pend_t pend; // Latch as seen on the port
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_fail, compares, cycles;
  // ----------------------------------------------------------
  // Design and core model
  // ----------------------------------------------------------
  irlg_latch irlg_latch_inst (
    .sys_clk_in(clk), .rst_in(rst), .clk_en_in(clk_en),
    .pwm_timer_req_in(src_req[7]), .converter_req_in(src_req[5]),
    .comparator_req_in(src_req[4]), .timer_zero_req_in(src_req[3]),
    .uart_rx_req_in(src_req[2]), .uart_tx_req_in(src_req[1]),
    .spi_req_in(src_req[0]), .fault_pin_a_in(flt[0]),
    .fault_pin_b_in(flt[1]), .fault_cmp_in(flt[2]),
    .fault_src_en_in(flt_en), .global_interrupt_enable_in(gie),
    .src_enable_in(src_en), .vec_ack_in(vec_ack),
    .vec_ack_index_in(vec_idx), .vectored_req_out(vreq),
    .pending_request_group_a_out(pend),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  irlg_core_model irlg_core_model_inst (
    .sys_clk_in(clk), .rst_in(rst), .vectored_req_in(vreq),
    .pending_in(pend), .src_enable_in(src_en), .ack_en_in(ack_en),
    .ack_delay_in(ack_dly), .vec_ack_out(vec_ack),
    .vec_ack_index_out(vec_idx)
  );
  // ----------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Ends a hung run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end
  // Verdict and end of run
  task automatic stop_test();
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_fail = n_fail + 1;
    end
  endtask
  // ----------------------------------------------------------
  // AXI4-Lite master tasks
  // ----------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel released at its own handshake edge
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Single read, data taken at the rvalid edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    gie = 1'b0;
    ack_en = 1'b0;
    ack_dly = 4'h0;
    src_req = 8'h00;
    src_en = 8'hFF;
    flt = 3'h0;
    flt_en = 3'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset value
    rd(`IRLG_REQ_ADDR, d, r);
    chk(d, 32'h0);
    // Each source except the fault bit sets its own bit, polled while disabled
    for (int i = 0; i < 8; i++) begin
      if (i != `IRLG_BIT_FAULT) begin
        src_req <= 8'h01 << i;
        @(posedge clk);
        src_req <= 8'h00;
        @(posedge clk);
        chk(32'(pend), 32'h1 << i);
        chk(32'(vreq), 32'h0);
        rd(`IRLG_REQ_ADDR, d, r);
        chk(d, 32'h1 << i);
        wr(`IRLG_REQ_ADDR, 32'h0, 4'hF, r);
        chk(32'(pend), 32'h0);
      end
    end
    // Low lane strobe off, unmapped places, software set
    wr(`IRLG_REQ_ADDR, 32'h5A, 4'h0, r);
    chk(32'(pend), 32'h0);
    wr(12'h100, 32'hFF, 4'hF, r);
    chk(32'(r), 32'(`IRLG_RESP_SLVERR));
    rd(12'h104, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(`IRLG_RESP_SLVERR));
    wr(`IRLG_REQ_ADDR, 32'hFFFFFFA5, 4'hF, r);
    chk(32'(r), 32'(`IRLG_RESP_OKAY));
    rd(`IRLG_REQ_ADDR, d, r);
    chk(d, 32'hA5);
    wr(`IRLG_REQ_ADDR, 32'h0, 4'hF, r);
    // Fault sources, each gated by its own enable
    for (int i = 0; i < 3; i++) begin
      flt_en <= 3'h7 ^ (3'h1 << i);
      flt <= 3'h1 << i;
      @(posedge clk);
      @(posedge clk);
      chk(32'(pend), 32'h0);
      flt <= 3'h0;
      flt_en <= 3'h1 << i;
      @(posedge clk);
      flt <= 3'h1 << i;
      @(posedge clk);
      @(posedge clk);
      chk(32'(pend), 32'h40);
      flt <= 3'h0;
      wr(`IRLG_REQ_ADDR, 32'h0, 4'hF, r);
    end
    // Vectored mode with a slow core, only enabled bits vector
    ack_dly <= 4'h5;
    ack_en <= 1'b1;
    src_en <= 8'h01;
    wr(`IRLG_REQ_ADDR, 32'h03, 4'hF, r);
    repeat (10) @(posedge clk);
    chk(32'(pend), 32'h03);
    chk(32'(vreq), 32'h0);
    gie <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(32'(vreq), 32'h1);
    for (int k = 0; k < 40 && pend[0] !== 1'b0; k++) @(posedge clk);
    chk(32'(pend), 32'h02);
    chk(32'(vreq), 32'h0);
    // Prompt core; a held request survives ack and software clear
    ack_dly <= 4'h0;
    src_req <= 8'h02;
    src_en <= 8'h02;
    repeat (8) @(posedge clk);
    chk(32'(pend), 32'h02);
    wr(`IRLG_REQ_ADDR, 32'h0, 4'hF, r);
    chk(32'(pend), 32'h02);
    src_req <= 8'h00;
    for (int k = 0; k < 40 && pend[1] !== 1'b0; k++) @(posedge clk);
    chk(32'(pend), 32'h0);
    gie <= 1'b0;
    // Frozen: a held request and the bus wait for the clock enable
    clk_en <= 1'b0;
    src_req <= 8'h10;
    repeat (3) @(posedge clk);
    chk(32'(pend), 32'h0);
    chk(32'(arready), 32'h0);
    clk_en <= 1'b1;
    @(posedge clk);
    src_req <= 8'h00;
    @(posedge clk);
    chk(32'(pend), 32'h10);
    wr(`IRLG_REQ_ADDR, 32'h0, 4'hF, r);
    chk(32'(pend), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
